// ==== inc/hsio_defs.svh ====
// constants of the interrupt and switch output block
// assumes a 200 MHz core clock; included by bare name
`ifndef HSIO_DEFS_SVH
`define HSIO_DEFS_SVH

// interrupt routing codes
`define HSIO_ROUTE_NONE      3'h0
`define HSIO_ROUTE_PIN_A     3'h1
`define HSIO_ROUTE_PIN_B     3'h2
`define HSIO_ROUTE_SCL       3'h3
`define HSIO_ROUTE_SCL_IDLE  3'h4
`define HSIO_ROUTE_UNIPOLAR  3'h5
`define HSIO_ROUTE_OMNIPOLAR 3'h6

// operating mode code for wake-up/sleep cycling
`define HSIO_OP_WAKE_SLEEP   2'h3
// pulse/latch select value meaning fixed-width pulse
`define HSIO_SEL_PULSE       1'b1

// timing
`define HSIO_CLK_PERIOD_NS   5
`define HSIO_PULSE_WIDTH_NS  10000
`define HSIO_WAIT_TIME_NS    1000000
`define HSIO_WAKE_BASE_NS    1000000
`define HSIO_PULSE_CYC  ((`HSIO_PULSE_WIDTH_NS + `HSIO_CLK_PERIOD_NS - 1) / `HSIO_CLK_PERIOD_NS)
`define HSIO_WAIT_CYC   (`HSIO_WAIT_TIME_NS / `HSIO_CLK_PERIOD_NS)
`define HSIO_WAKE_CYC   (`HSIO_WAKE_BASE_NS / `HSIO_CLK_PERIOD_NS)

// counter widths
`define HSIO_PULSE_W    12
`define HSIO_TMR_W      24

// reset values
`define HSIO_RST_WATCH  2'h0

`endif

// ==== inc/hsio_pkg.sv ====
// types of the interrupt and switch output block
// assumes hsio_defs.svh is available on the include path
package hsio_pkg;
    // one-hot power and wait sequencing states
    typedef enum logic [4:0] {
        ST_RUN   = 5'h01,
        ST_SLEEP = 5'h02,
        ST_AWAKE = 5'h04,
        ST_WAIT  = 5'h08,
        ST_CFG   = 5'h10
    } hsio_state_e;

    // interrupt routing field
    typedef logic [2:0] hsio_route_t;
endpackage

// ==== inc/hsio_cdc_if.sv ====
// crossing carrier between the link-side logic and the core
// assumes the core synchronises every signal it reads here
`timescale 1ns/1ps
interface hsio_cdc_if;
    logic addr_tgl;    // flips once per own valid address

    modport link (output addr_tgl);
    modport core (input  addr_tgl);
endinterface

// ==== design/hsio_sync.sv ====
// two-flop level synchroniser of parameterised width
// assumes the reader looks only at q_o, never at the first stage
`timescale 1ns/1ps
module hsio_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;    // first stage, read by q_o only

    // both stages frozen while the enable is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else if (en_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ==== design/hsio_link.sv ====
// link-side logic on the bus clock: address events to a toggle
// assumes addr_hit_i is a one-cycle pulse on link_clk_i
`timescale 1ns/1ps
module hsio_link (
    input  wire logic link_clk_i,
    input  wire logic rst_n_i,
    input  wire logic addr_hit_i,
    hsio_cdc_if.link  cdc
);
    logic tgl;         // event toggle, level survives a stopped clock
    logic next_tgl;    // next toggle value

    // flip once per valid own address
    always_comb begin
        next_tgl = tgl ^ addr_hit_i;
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl <= 1'b0;
        end else begin
            tgl <= next_tgl;
        end
    end

    assign cdc.addr_tgl = tgl;
endmodule

// ==== design/hsio_top.sv ====
// interrupt and switch output logic of a three-axis hall sensor
// assumes conversion and threshold flags come from the core clock;
// bus busy and addressed levels arrive asynchronously
`timescale 1ns/1ps
`include "hsio_defs.svh"
module hsio_top
    import hsio_pkg::*;
#(
    parameter logic [`HSIO_TMR_W-1:0] WAIT_CYC =
        `HSIO_TMR_W'(`HSIO_WAIT_CYC),
    parameter logic [`HSIO_TMR_W-1:0] WAKE_BASE_CYC =
        `HSIO_TMR_W'(`HSIO_WAKE_CYC)
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       link_clk_i,
    input  wire logic [2:0] irq_route_i,
    input  wire logic       irq_polarity_sel_i,
    input  wire logic       pulse_sel_i,
    input  wire logic [1:0] op_mode_i,
    input  wire logic [1:0] wake_interval_sel_i,
    input  wire logic [1:0] change_watch_sel_i,
    input  wire logic       conv_done_i,
    input  wire logic       thr_cross_i,
    input  wire logic       sw_pos_i,
    input  wire logic       sw_neg_i,
    input  wire logic       result_read_i,
    input  wire logic       resume_i,
    input  wire logic       bus_busy_i,
    input  wire logic       dev_addressed_i,
    input  wire logic       addr_hit_i,
    output logic            int_o,
    output logic            int_oe_o,
    output logic            scl_o,
    output logic            scl_oe_o,
    output logic            result_upd_o,
    output logic            set_count_upd_o,
    output logic            meas_req_o,
    output logic            ack_en_o,
    output logic            low_power_o,
    output logic            wait_o,
    output logic            config_mode_o,
    output logic [1:0]      change_watch_o
);

    // route decode: interrupt pin family
    function automatic logic is_pin(input hsio_route_t r);
        is_pin = (r == `HSIO_ROUTE_PIN_A) || (r == `HSIO_ROUTE_PIN_B) ||
                 (r == `HSIO_ROUTE_UNIPOLAR) ||
                 (r == `HSIO_ROUTE_OMNIPOLAR);
    endfunction

    // route decode: clock line family
    function automatic logic is_scl(input hsio_route_t r);
        is_scl = (r == `HSIO_ROUTE_SCL) || (r == `HSIO_ROUTE_SCL_IDLE);
    endfunction

    // route decode: either switch mode
    function automatic logic is_switch(input hsio_route_t r);
        is_switch = (r == `HSIO_ROUTE_UNIPOLAR) ||
                    (r == `HSIO_ROUTE_OMNIPOLAR);
    endfunction

    // wake interval: base period doubled per select step
    function automatic logic [`HSIO_TMR_W-1:0] wake_cycles(
        input logic [1:0] sel
    );
        wake_cycles = WAKE_BASE_CYC << sel;
    endfunction

    localparam logic [`HSIO_PULSE_W-1:0] PULSE_CYC =
        `HSIO_PULSE_W'(`HSIO_PULSE_CYC);

    logic        rst_sync_n;    // released copy of the reset
    logic [2:0]  sync_q;        // {addr toggle, busy, addressed}
    logic        busy_s;        // synchronised bus busy
    logic        addressed_s;   // synchronised addressed level
    logic        addr_hit;      // one-cycle own-address event

    hsio_cdc_if  u_cdc ();      // link to core carrier

    // reset release through two flops
    hsio_sync #(.W(1)) u_rst_sync (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (1'b1),
        .d_i     (1'b1),
        .q_o     (rst_sync_n)
    );

    // address events collected on the bus clock
    hsio_link u_link (
        .link_clk_i (link_clk_i),
        .rst_n_i    (rst_n_i),
        .addr_hit_i (addr_hit_i),
        .cdc        (u_cdc.link)
    );

    // async levels and toggle into the core domain
    hsio_sync #(.W(3)) u_in_sync (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_sync_n),
        .en_i    (clk_en_i),
        .d_i     ({u_cdc.addr_tgl, bus_busy_i, dev_addressed_i}),
        .q_o     (sync_q)
    );

    assign busy_s      = sync_q[1];
    assign addressed_s = sync_q[0];

    // state registers
    hsio_state_e              state;        // sequencing state
    logic [`HSIO_TMR_W-1:0]   tmr;          // sleep or wait countdown
    logic [`HSIO_PULSE_W-1:0] pulse_cnt;    // fixed pulse remaining
    logic                     latch;        // latched interrupt
    logic                     sw_level;     // switch output state
    logic                     engaged;      // host engaged in wait
    logic                     tgl_d;        // last seen toggle

    // next values
    hsio_state_e              next_state;
    logic [`HSIO_TMR_W-1:0]   next_tmr;
    logic [`HSIO_PULSE_W-1:0] next_pulse;
    logic                     next_latch;
    logic                     next_sw;
    logic                     next_engaged;
    logic                     next_int_oe;
    logic                     next_scl_oe;
    logic                     next_res_upd;
    logic                     next_cnt_upd;
    logic                     next_meas;
    logic                     next_ack_en;
    logic                     next_low_power;
    logic                     next_wait;
    logic                     next_cfg;
    logic [1:0]               next_watch;

    // decode helpers
    logic ws;           // wake-up/sleep mode selected
    logic upd_ok;       // result and counter updates allowed
    logic evt;          // threshold event that signals
    logic latched;      // event is to be latched
    logic pin_act;      // pin asserting its interrupt
    logic pin_level;    // level the pin should present

    assign addr_hit = sync_q[2] ^ tgl_d;

    // next-state and output computation
    always_comb begin
        next_state   = state;
        next_tmr     = tmr;
        next_pulse   = pulse_cnt;
        next_latch   = latch;
        next_sw      = sw_level;
        next_engaged = engaged;
        next_meas    = 1'b0;
        ws = (op_mode_i == `HSIO_OP_WAKE_SLEEP);

        // code 4h updates only on an idle bus
        if (irq_route_i == `HSIO_ROUTE_SCL_IDLE) begin
            upd_ok = ~busy_s;
        end else begin
            // other codes hold off while talked to
            upd_ok = ~(busy_s & addressed_s);
        end
        next_res_upd = conv_done_i & upd_ok;
        next_cnt_upd = conv_done_i & upd_ok;

        // signalling event, code 0h gives none
        evt = conv_done_i & thr_cross_i &
              (irq_route_i != `HSIO_ROUTE_NONE) &
              ~is_switch(irq_route_i) &
              ~((irq_route_i == `HSIO_ROUTE_SCL_IDLE) & busy_s);
        latched = is_pin(irq_route_i) & (pulse_sel_i != `HSIO_SEL_PULSE);

        // fixed-width pulse countdown
        if (pulse_cnt != '0) begin
            next_pulse = pulse_cnt - 1'b1;
        end
        if (evt & ~latched) begin
            next_pulse = PULSE_CYC;
        end

        // latch: own address clears, new event wins
        if (addr_hit) begin
            next_latch = 1'b0;
        end
        if (evt & latched) begin
            next_latch = 1'b1;
        end

        // switch outputs follow each conversion
        if (!is_switch(irq_route_i)) begin
            next_sw = 1'b0;
        end else if (conv_done_i) begin
            if (irq_route_i == `HSIO_ROUTE_UNIPOLAR) begin
                next_sw = sw_pos_i;
            end else begin
                next_sw = sw_pos_i | sw_neg_i;
            end
        end

        // sequencing between run, sleep, wait and config
        unique case (state)
            ST_RUN: begin
                if (ws) begin
                    next_state = ST_SLEEP;
                    next_tmr   = wake_cycles(wake_interval_sel_i);
                end else if (evt & latched) begin
                    next_state = ST_CFG;
                end
            end
            ST_SLEEP: begin
                if (!ws) begin
                    next_state = ST_RUN;
                end else if (addr_hit) begin
                    // own address wakes, no acknowledge
                    next_state = ST_AWAKE;
                    next_meas  = 1'b1;
                end else if (tmr == '0) begin
                    next_state = ST_AWAKE;
                    next_meas  = 1'b1;
                end else begin
                    next_tmr = tmr - 1'b1;
                end
            end
            ST_AWAKE: begin
                if (!ws) begin
                    next_state = ST_RUN;
                end else if (conv_done_i) begin
                    if (evt) begin
                        // post-event wait
                        next_state   = ST_WAIT;
                        next_tmr     = WAIT_CYC;
                        next_engaged = 1'b0;
                    end else begin
                        // switches never wait
                        next_state = ST_SLEEP;
                        next_tmr   = wake_cycles(wake_interval_sel_i);
                    end
                end
            end
            ST_WAIT: begin
                // results stay readable here
                if (addr_hit | result_read_i) begin
                    next_engaged = 1'b1;
                end
                if (resume_i) begin
                    // host resumes cycling
                    next_state = ST_SLEEP;
                    next_tmr   = wake_cycles(wake_interval_sel_i);
                end else if (!next_engaged && tmr == '0) begin
                    if (latched) begin
                        next_state = ST_CFG;
                    end else begin
                        next_state = ST_SLEEP;
                        next_tmr   = wake_cycles(wake_interval_sel_i);
                    end
                end else if (tmr != '0) begin
                    next_tmr = tmr - 1'b1;
                end
            end
            ST_CFG: begin
                if (resume_i) begin
                    next_state = ws ? ST_SLEEP : ST_RUN;
                    next_tmr   = wake_cycles(wake_interval_sel_i);
                end
            end
            default: begin
                // illegal one-hot code recovers to run
                next_state = ST_RUN;
            end
        endcase

        // pin activity, pin routes only
        pin_act = is_pin(irq_route_i) &
                  ((next_pulse != '0) | next_latch | next_sw);
        // polarity picks asserted level
        pin_level   = irq_polarity_sel_i ? pin_act : ~pin_act;
        // open drain: enable only to pull low
        next_int_oe = ~pin_level;
        // clock line pulled low for the pulse
        next_scl_oe = is_scl(irq_route_i) & (next_pulse != '0);

        // status levels
        next_ack_en    = (next_state != ST_SLEEP);
        next_low_power = (next_state == ST_SLEEP) |
                         ((next_state == ST_WAIT) & ~next_engaged);
        next_wait      = (next_state == ST_WAIT);
        next_cfg       = (next_state == ST_CFG);
        // change watch disabled in switch modes
        next_watch = is_switch(irq_route_i) ? 2'h0 : change_watch_sel_i;
    end

    // registers, frozen while the clock enable is low
    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state           <= ST_RUN;
            tmr             <= '0;
            pulse_cnt       <= '0;
            latch           <= 1'b0;
            sw_level        <= 1'b0;
            engaged         <= 1'b0;
            tgl_d           <= 1'b0;
            int_o           <= 1'b0;
            int_oe_o        <= 1'b0;
            scl_o           <= 1'b0;
            scl_oe_o        <= 1'b0;
            result_upd_o    <= 1'b0;
            set_count_upd_o <= 1'b0;
            meas_req_o      <= 1'b0;
            ack_en_o        <= 1'b1;
            low_power_o     <= 1'b0;
            wait_o          <= 1'b0;
            config_mode_o   <= 1'b0;
            change_watch_o  <= `HSIO_RST_WATCH;
        end else if (clk_en_i) begin
            state           <= next_state;
            tmr             <= next_tmr;
            pulse_cnt       <= next_pulse;
            latch           <= next_latch;
            sw_level        <= next_sw;
            engaged         <= next_engaged;
            tgl_d           <= sync_q[2];
            int_oe_o        <= next_int_oe;
            scl_oe_o        <= next_scl_oe;
            result_upd_o    <= next_res_upd;
            set_count_upd_o <= next_cnt_upd;
            meas_req_o      <= next_meas;
            ack_en_o        <= next_ack_en;
            low_power_o     <= next_low_power;
            wait_o          <= next_wait;
            config_mode_o   <= next_cfg;
            change_watch_o  <= next_watch;
        end
    end
endmodule

// ==== dv/hsio_top_assertions.sv ====
// checker of the interrupt and switch output block
// assumes it is bound into hsio_top and sees only its ports
`timescale 1ns/1ps
`include "hsio_defs.svh"
module hsio_top_assertions #(
    parameter logic [`HSIO_TMR_W-1:0] WAIT_CYC      = `HSIO_TMR_W'(20),
    parameter logic [`HSIO_TMR_W-1:0] WAKE_BASE_CYC = `HSIO_TMR_W'(16)
) (
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic       clk_en_i,
    input wire logic       link_clk_i,
    input wire logic [2:0] irq_route_i,
    input wire logic       irq_polarity_sel_i,
    input wire logic       pulse_sel_i,
    input wire logic [1:0] op_mode_i,
    input wire logic [1:0] wake_interval_sel_i,
    input wire logic [1:0] change_watch_sel_i,
    input wire logic       conv_done_i,
    input wire logic       thr_cross_i,
    input wire logic       sw_pos_i,
    input wire logic       sw_neg_i,
    input wire logic       result_read_i,
    input wire logic       resume_i,
    input wire logic       bus_busy_i,
    input wire logic       dev_addressed_i,
    input wire logic       addr_hit_i,
    input wire logic       int_o,
    input wire logic       int_oe_o,
    input wire logic       scl_o,
    input wire logic       scl_oe_o,
    input wire logic       result_upd_o,
    input wire logic       set_count_upd_o,
    input wire logic       meas_req_o,
    input wire logic       ack_en_o,
    input wire logic       low_power_o,
    input wire logic       wait_o,
    input wire logic       config_mode_o,
    input wire logic [1:0] change_watch_o
);
    localparam int PULSE = `HSIO_PULSE_CYC;  // pulse width in cycles
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    int gap;       // running cycles since the last threshold event
    int next_gap;
    // restart on each taken threshold event, frozen with the clock enable
    always_comb begin
        next_gap = gap;
        if (clk_en_i && conv_done_i && thr_cross_i)
            next_gap = 0;
        else if (clk_en_i && gap < 100000)
            next_gap = gap + 1;
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            gap <= 100000;
        else
            gap <= next_gap;
    end
    AST_INT_OPEN_DRAIN: assert property (int_o == 1'b0)
        else $error("interrupt pin data driven high");
    AST_SCL_OPEN_DRAIN: assert property (scl_o == 1'b0)
        else $error("clock line data driven high");
    AST_UPD_PAIR: assert property (result_upd_o == set_count_upd_o)
        else $error("result and set count updates differ");
    AST_UPD_CAUSE: assert property (result_upd_o |->
        $past(conv_done_i && clk_en_i)) else $error("update without conversion");
    AST_SCL_ROUTE: assert property ($rose(scl_oe_o) |->
        $past(irq_route_i == 3'h3 || irq_route_i == 3'h4))
        else $error("clock line pulse on wrong route");
    AST_SCL_WIDTH: assert property ($fell(scl_oe_o) |-> gap == PULSE)
        else $error("clock line pulse width wrong");
    AST_WAIT_ENTRY: assert property ($rose(wait_o) |->
        $past(op_mode_i) == 2'h3 && $past(irq_route_i) < 3'h5)
        else $error("wait state entered wrongly");
    AST_CFG_LATCH: assert property ($rose(config_mode_o) |->
        !$past(pulse_sel_i)) else $error("config mode without latch");
    AST_SLEEP_NOACK: assert property (low_power_o && !wait_o |->
        !ack_en_o) else $error("acknowledge enabled while asleep");
    AST_WATCH_OFF: assert property ((clk_en_i &&
        (irq_route_i == 3'h5 || irq_route_i == 3'h6))[*6] |->
        change_watch_o == 2'h0) else $error("change watch on in switch mode");
    AST_WATCH_PASS: assert property ((clk_en_i && irq_route_i < 3'h5 &&
        $stable(change_watch_sel_i))[*6] |->
        change_watch_o == change_watch_sel_i)
        else $error("change watch select not passed");
endmodule
bind hsio_top hsio_top_assertions #(.WAIT_CYC(WAIT_CYC),
    .WAKE_BASE_CYC(WAKE_BASE_CYC)) u_chk (.*);

// ==== dv/hsio_host.sv ====
// bus controller model: address frames with busy and addressed levels
// assumes the bench wire-ands its clock with the sensor pull-down
`timescale 1ns/1ps
module hsio_host (
    output logic scl_o,        // bus clock, idles high outside frames
    output logic busy_o,       // bus busy level
    output logic addressed_o,  // this device addressed
    output logic hit_o         // own address seen, one bus clock
);
    initial begin
        scl_o = 1'b1;
        busy_o = 1'b0;
        addressed_o = 1'b0;
        hit_o = 1'b0;
    end
    // one address frame; other-target frames only on request
    task automatic frame(input logic own);
        int i;
        busy_o = 1'b1;
        #23.3;
        for (i = 0; i < 10; i++) begin
            #6 scl_o = 1'b0;
            #6 scl_o = 1'b1;
            #1;
            hit_o = own && i == 7;  // held across one rising edge
            if (i == 7)
                addressed_o = own;
        end
        #20;
        busy_o = 1'b0;
        addressed_o = 1'b0;
    endtask
endmodule

// ==== dv/test_hsio_top.sv ====
// self-checking bench of the interrupt and switch output block
// assumes short wait and wake parameters; bus frames from hsio_host
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module test_hsio_top;
    logic       ref_clk_i, rst_n_i, clk_en_i, irq_polarity_sel_i;
    logic [2:0] irq_route_i;
    logic [1:0] op_mode_i, wake_interval_sel_i, change_watch_sel_i;
    logic [1:0] change_watch_o;
    logic       pulse_sel_i, conv_done_i, thr_cross_i, sw_pos_i, sw_neg_i;
    logic       result_read_i, resume_i, host_scl, bus_busy_i;
    logic       dev_addressed_i, addr_hit_i, int_o, int_oe_o, scl_o;
    logic       scl_oe_o, result_upd_o, set_count_upd_o, meas_req_o;
    logic       ack_en_o, low_power_o, wait_o, config_mode_o;
    wire        link_clk_i;
    int         failures, num_checks, k;
    hsio_top #(.WAIT_CYC(24'h14), .WAKE_BASE_CYC(24'h10)) dut (.*);
    hsio_host host (.scl_o(host_scl), .busy_o(bus_busy_i),
        .addressed_o(dev_addressed_i), .hit_o(addr_hit_i));
    assign link_clk_i = host_scl & ~scl_oe_o;  // wired-and clock line
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge ref_clk_i) rst_n_i <= 1'b0;
        wt(4);
        `CHK(int_oe_o, 1'b0)
        `CHK(ack_en_o, 1'b1)
        @(posedge ref_clk_i) rst_n_i <= 1'b1;
        wt(6);
    endtask
    // one conversion pulse, returns just after the edge that takes it
    task automatic conv(input logic t, p, n);
        @(posedge ref_clk_i);
        conv_done_i <= 1'b1;
        thr_cross_i <= t;
        sw_pos_i <= p;
        sw_neg_i <= n;
        @(posedge ref_clk_i) conv_done_i <= 1'b0;
        #1;
    endtask
    // threshold event under a route and bus condition
    task automatic evt(input logic [2:0] r, input logic own, busy);
        logic up, sc;
        up = !busy || (r != 3'h4 && !own);
        sc = r == 3'h3 || (r == 3'h4 && !busy);
        @(posedge ref_clk_i) irq_route_i <= r;
        if (busy)
            fork host.frame(own); join_none
        wt(30);  // frame must reach its address byte first
        conv(1'b1, 1'b0, 1'b0);
        `CHK(result_upd_o, up)
        `CHK(set_count_upd_o, up)
        `CHK(scl_oe_o, sc)
        `CHK(int_oe_o, r == 3'h1 || r == 3'h2)
        wt(2150);
    endtask
    task automatic sw(input logic p, n, e);
        conv(p | n, p, n);
        `CHK(int_oe_o, e)
    endtask
    task automatic wait_lp(input logic v, output int c);
        c = 0;
        while (low_power_o !== v && c < 400) begin
            wt(1);
            c++;
        end
        `CHK(low_power_o, v)
    endtask
    // watchdog against a hung handshake
    initial begin
        #400us;
        failures++;
        give_verdict();
    end
    initial begin
        {failures, num_checks} = '0;
        {rst_n_i, conv_done_i, thr_cross_i, sw_pos_i, sw_neg_i} = '0;
        {irq_polarity_sel_i, result_read_i, resume_i, op_mode_i} = '0;
        {clk_en_i, pulse_sel_i, irq_route_i} = 5'h19;
        wake_interval_sel_i = 2'h3;
        change_watch_sel_i = 2'h2;
        do_reset();
        `CHK(change_watch_o, 2'h2)
        conv(1'b1, 1'b0, 1'b0);
        `CHK(result_upd_o, 1'b1)
        `CHK(int_oe_o, 1'b1)
        wt(1999);
        `CHK(result_upd_o, 1'b0)
        `CHK(int_oe_o, 1'b1)
        wt(1);
        `CHK(int_oe_o, 1'b0)
        evt(3'h1, 1'b0, 1'b0);
        evt(3'h1, 1'b1, 1'b1);
        evt(3'h2, 1'b0, 1'b1);
        evt(3'h3, 1'b1, 1'b1);
        evt(3'h3, 1'b0, 1'b0);
        evt(3'h4, 1'b0, 1'b1);
        evt(3'h4, 1'b0, 1'b0);
        @(posedge ref_clk_i);
        irq_route_i <= 3'h1;
        irq_polarity_sel_i <= 1'b1;
        wt(4);
        `CHK(int_oe_o, 1'b1)
        `CHK({int_o, scl_o}, 2'h0)
        conv(1'b1, 1'b0, 1'b0);
        `CHK(int_oe_o, 1'b0)
        wt(2010);
        `CHK(int_oe_o, 1'b1)
        @(posedge ref_clk_i);
        irq_polarity_sel_i <= 1'b0;
        pulse_sel_i <= 1'b0;
        conv(1'b1, 1'b0, 1'b0);
        `CHK(int_oe_o, 1'b1)
        wt(3000);
        `CHK(int_oe_o, 1'b1)
        `CHK(config_mode_o, 1'b1)
        host.frame(1'b1);
        wt(10);
        `CHK(int_oe_o, 1'b0)
        @(posedge ref_clk_i) resume_i <= 1'b1;
        @(posedge ref_clk_i) resume_i <= 1'b0;
        wt(3);
        `CHK(config_mode_o, 1'b0)
        @(posedge ref_clk_i);
        pulse_sel_i <= 1'b1;
        irq_route_i <= 3'h5;
        wt(8);
        `CHK(change_watch_o, 2'h0)
        sw(1'b1, 1'b0, 1'b1);
        sw(1'b0, 1'b1, 1'b0);
        @(posedge ref_clk_i) irq_route_i <= 3'h6;
        wt(3);
        sw(1'b0, 1'b1, 1'b1);
        sw(1'b0, 1'b0, 1'b0);
        sw(1'b1, 1'b0, 1'b1);
        @(posedge ref_clk_i);
        irq_route_i <= 3'h3;
        op_mode_i <= 2'h3;
        wait_lp(1'b1, k);
        wait_lp(1'b0, k);
        `CHK(meas_req_o, 1'b1)
        conv(1'b0, 1'b0, 1'b0);
        wait_lp(1'b1, k);
        wait_lp(1'b0, k);
        `CHK(k >= 128 && k <= 132, 1'b1)
        conv(1'b0, 1'b0, 1'b0);
        wait_lp(1'b1, k);
        host.frame(1'b1);
        wt(6);
        `CHK(ack_en_o, 1'b1)
        `CHK(low_power_o, 1'b0)
        conv(1'b1, 1'b0, 1'b0);
        `CHK(scl_oe_o, 1'b1)
        wt(2);
        `CHK(wait_o, 1'b1)
        wt(24);
        `CHK(wait_o, 1'b0)
        `CHK(low_power_o, 1'b1)
        do_reset();
        `CHK(scl_oe_o, 1'b0)
        give_verdict();
    end
endmodule
